// *** design/sar_frame_pkg.sv ***
/*
  Shared constants and types for the serial readout frame of the 10-bit sampling converter.
  Assumes one 20 MHz system clock on both ends of the link.
*/
package sar_frame_pkg;
   localparam int CODE_W = 10;
   localparam int WORD_W = 12;
   localparam int NEG_W = 7;
   localparam int OFFSET_W = 6;
   localparam int DIFF_W = 12;
   localparam int CNT_W = 6;

   localparam logic [CODE_W-1:0] BOTTOM_SCALE_CODE = 10'h000;
   localparam logic [CODE_W-1:0] MIDDLE_SCALE_CODE = 10'h200;
   localparam logic [CODE_W-1:0] TOP_SCALE_CODE = 10'h3FF;

   localparam logic [CNT_W-1:0] WORD_FALLS = 6'h0C;
   localparam logic [CNT_W-1:0] PWRUP_CAL_FALLS = 6'h10;
   localparam logic [CNT_W-1:0] RECAL_START_FALL = 6'h11;
   localparam logic [CNT_W-1:0] RECAL_FALLS = 6'h20;
   localparam logic [CNT_W-1:0] CAL_PERIODS = 6'h0F;

   localparam int CLK_PERIOD_NS = 50;
   localparam int ACQUIRE_INTERVAL_NS = 235;
   localparam int SELECT_TO_CLOCK_SETUP_NS = 15;
   localparam int SELECT_HIGH_NS = 60;
   localparam int LAST_CLOCK_TO_SELECT_NS = 10;
   localparam int ACQUIRE_INTERVAL_CYC = (ACQUIRE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_TO_CLOCK_SETUP_CYC =
      (SELECT_TO_CLOCK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_HIGH_CYC = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LAST_CLOCK_TO_SELECT_CYC =
      (LAST_CLOCK_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (ACQUIRE_INTERVAL_CYC > SELECT_HIGH_CYC) ?
      ACQUIRE_INTERVAL_CYC : SELECT_HIGH_CYC;

   localparam int HALF_PERIOD_CYC = 8;
   localparam int HALF_MIN_CYC = 4;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_LOW = 2'b01,
      H_HIGH = 2'b10,
      H_GAP = 2'b11
   } host_state_e;
endpackage

// *** design/adc_link_if.sv ***
/*
  Serial link between the converter and its host: select, serial clock, data out.
  Assumes the testbench joins both ends; released data reads low on the line.
*/
`timescale 1ns/1ns
interface adc_link_if;
   logic cs_n;
   logic sclk;
   logic sdo;
   logic sdo_oe_n;
   logic sdo_line;

   // Released line seen as low, as with a pull-down
   assign sdo_line = ~sdo_oe_n & sdo;

   modport device (
      input cs_n,
      input sclk,
      output sdo,
      output sdo_oe_n
   );
   modport host (
      output cs_n,
      output sclk,
      input sdo_line
   );
endinterface

// *** design/sar_frame_device.sv ***
/*
  Converter end of the serial frame: sampling at select fall, word shift-out,
  power-up and in-operation offset calibration with its hidden correction store.
  Assumes select and serial clock arrive from the host unsynchronised and the
  analog value is presented as codes on the system clock.
*/
// Operation
// - Clamp input difference to bottom and top codes
// - Plain unsigned binary, ten bits resolution
// - Frame runs from select fall to rise
// - Host waits setup before first clock fall
// - Serial clock drives conversion; two zeros, result
// - First zero at select fall, rest per fall
// - Output low after twelve clocks
// - Select rise ends frame, releases output
// - Host leaves acquire interval between frames
// - First frame calibrates, output stays low
// - Power-up calibration needs sixteen clock falls
// - Short first frame leaves store unchanged
// - Host waits acquire interval after calibration
// - Store clears at reset, hidden from link
// - Inputs disconnected while calibrating
// - Results corrected by stored offset
// - Thirty-two falls in frame recalibrate
// - Long frame: word, calibrate falls 17-32
// - Frames after the first under thirty-two falls keep store
// - Host limits clock rate in calibration; this host keeps one HALF for every frame
// - Calibration spans fifteen clock periods
`timescale 1ns/1ns
module sar_frame_device
   import sar_frame_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   adc_link_if.device link,
   input wire logic [CODE_W-1:0] analog_in_pos,
   input wire logic signed [NEG_W-1:0] analog_in_neg,
   input wire logic signed [OFFSET_W-1:0] offset_sense,
   output logic inputs_disconnect,
   output logic frame_active,
   output logic [CODE_W-1:0] result_code,
   output logic result_valid,
   output logic cal_done
);
   typedef struct packed {
      logic [1:0] cs_sync;
      logic [1:0] ck_sync;
      logic cs_prev;
      logic ck_prev;
      logic in_frame;
      logic first_pending;
      logic cal_frame;
      logic [CNT_W-1:0] falls;
      logic [WORD_W-1:0] shift;
      logic drive_n;
      logic signed [OFFSET_W-1:0] offset_correction_store;
      logic disc;
      logic [CODE_W-1:0] code;
      logic code_valid;
      logic done;
   } dev_s;

   localparam dev_s DEV_RESET = '{
      cs_sync: 2'h3,
      ck_sync: 2'h3,
      cs_prev: 1'b1,
      ck_prev: 1'b1,
      in_frame: 1'b0,
      first_pending: 1'b1,
      cal_frame: 1'b0,
      falls: '0,
      shift: '0,
      drive_n: 1'b1,
      offset_correction_store: '0,
      disc: 1'b0,
      code: '0,
      code_valid: 1'b0,
      done: 1'b0
   };

   dev_s q;
   dev_s d;
   logic cs_s;
   logic ck_s;
   logic cs_fall;
   logic cs_rise;
   logic ck_fall;
   logic [CNT_W-1:0] falls_next;
   logic [CODE_W-1:0] conv;

   // Ideal transfer: floor of the corrected difference, clamped at both ends
   function automatic logic [CODE_W-1:0] convert(
      input logic [CODE_W-1:0] pos,
      input logic signed [NEG_W-1:0] neg,
      input logic signed [OFFSET_W-1:0] ofs
   );
      logic signed [DIFF_W-1:0] diff;
      logic signed [DIFF_W-1:0] top;
      diff = $signed({2'b00, pos}) - DIFF_W'(neg) - DIFF_W'(ofs);
      top = $signed({2'b00, TOP_SCALE_CODE});
      if (diff < 0) begin
         return BOTTOM_SCALE_CODE;
      end else if (diff > top) begin
         return TOP_SCALE_CODE;
      end else begin
         return diff[CODE_W-1:0];
      end
   endfunction

   // True only on the fall that first brings the count to the target
   function automatic logic reaches(
      input logic [CNT_W-1:0] cur,
      input logic [CNT_W-1:0] nxt,
      input logic [CNT_W-1:0] tgt
   );
      return (cur != nxt) && (nxt == tgt);
   endfunction

   // Counter must pass the recal end, else a long frame never stores
   if (WORD_W != CODE_W + 2 || (1 << CNT_W) - 1 <= int'(RECAL_FALLS)) begin : g_bad_widths
      $error("sar_frame_device frame widths do not fit");
   end

   // Only the second stage of each synchroniser is looked at
   assign cs_s = q.cs_sync[1];
   assign ck_s = q.ck_sync[1];
   assign cs_fall = q.cs_prev & ~cs_s;
   assign cs_rise = ~q.cs_prev & cs_s;
   assign ck_fall = q.ck_prev & ~ck_s & q.in_frame & ~cs_s;
   // Counter saturates so very long frames cannot wrap into a new calibration
   assign falls_next = (q.falls == '1) ? q.falls : q.falls + 1'b1;
   assign conv = convert(analog_in_pos, analog_in_neg, q.offset_correction_store);

   always_comb begin
      d = q;
      d.cs_sync = {q.cs_sync[0], link.cs_n};
      d.ck_sync = {q.ck_sync[0], link.sclk};
      d.cs_prev = cs_s;
      d.ck_prev = ck_s;
      d.code_valid = 1'b0;
      d.done = 1'b0;
      if (cs_fall) begin
         d.in_frame = 1'b1;
         d.falls = '0;
         d.drive_n = 1'b0;
         d.first_pending = 1'b0;
         d.cal_frame = q.first_pending;
         if (q.first_pending) begin
            d.shift = '0;
            d.disc = 1'b1;
         end else begin
            d.shift = {2'b00, conv};
            d.code = conv;
            d.code_valid = 1'b1;
            d.disc = 1'b0;
         end
      end else if (cs_rise) begin
         d.in_frame = 1'b0;
         d.drive_n = 1'b1;
         d.shift = '0;
         d.disc = 1'b0;
         d.cal_frame = 1'b0;
      end else if (ck_fall) begin
         d.falls = falls_next;
         // shift, zero fill keeps line low
         d.shift = {q.shift[WORD_W-2:0], 1'b0};
         if (q.cal_frame) begin
            if (reaches(q.falls, falls_next, PWRUP_CAL_FALLS)) begin
               d.offset_correction_store = offset_sense;
               d.disc = 1'b0;
               d.done = 1'b1;
            end
         end else begin
            if (reaches(q.falls, falls_next, RECAL_START_FALL)) begin
               d.disc = 1'b1;
            end
            if (reaches(q.falls, falls_next, RECAL_FALLS)) begin
               d.offset_correction_store = offset_sense;
               d.disc = 1'b0;
               d.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= DEV_RESET;
      end else begin
         q <= d;
      end
   end

   assign link.sdo = q.shift[WORD_W-1];
   assign link.sdo_oe_n = q.drive_n;
   assign inputs_disconnect = q.disc;
   assign frame_active = q.in_frame;
   assign result_code = q.code;
   assign result_valid = q.code_valid;
   assign cal_done = q.done;
endmodule

// *** design/sar_frame_host.sv ***
/*
  Host end of the serial frame plus the result FIFO it fills.
  Assumes the converter end answers each clock fall within a few system cycles;
  the serial clock is made here from the system clock by a divider.
*/
`timescale 1ns/1ns
module result_fifo #(
   parameter int W = 10,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fifo_s;

   fifo_s q;
   fifo_s d;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("result_fifo depth must be a power of two");
   end

   assign in_ready = ~((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
   assign out_valid = q.wp != q.rp;
   assign out_data = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid && in_ready) begin
         d.mem[q.wp[AW-1:0]] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

module sar_frame_host
   import sar_frame_pkg::*;
#(
   parameter int HALF = HALF_PERIOD_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   adc_link_if.host link,
   input wire logic start,
   input wire logic [CNT_W-1:0] frame_clocks,
   output logic busy,
   output logic out_valid,
   input wire logic out_ready,
   output logic [CODE_W-1:0] out_data
);
   typedef struct packed {
      host_state_e st;
      logic [7:0] cnt;
      logic cs_n;
      logic sclk;
      logic [CNT_W-1:0] target;
      logic [CNT_W-1:0] falls;
      logic [WORD_W-1:0] rx;
      logic [3:0] nrx;
      logic first;
      logic [1:0] sdo_sync;
      logic push;
      logic [CODE_W-1:0] push_data;
   } host_s;

   localparam host_s HOST_RESET = '{
      st: H_IDLE, cnt: '0, cs_n: 1'b1, sclk: 1'b1, target: '0, falls: '0,
      rx: '0, nrx: '0, first: 1'b1, sdo_sync: '0, push: 1'b0, push_data: '0
   };
   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
   localparam logic [7:0] GAP_LAST = 8'(GAP_CYC - 1);

   host_s q;
   host_s d;
   logic push_ready;

   // Round trip through both synchronisers needs about five cycles per bit
   // slow clock bound
   if (HALF < HALF_MIN_CYC || HALF < SELECT_TO_CLOCK_SETUP_CYC ||
       HALF < LAST_CLOCK_TO_SELECT_CYC || HALF > 255) begin : g_bad_half
      $error("sar_frame_host half period out of range");
   end

   always_comb begin
      d = q;
      d.sdo_sync = {q.sdo_sync[0], link.sdo_line};
      d.push = 1'b0;
      case (q.st)
         H_IDLE: begin
            // A frame starts only with FIFO room, so its word is never dropped
            if (start && push_ready) begin
               d.cs_n = 1'b0;
               d.target = frame_clocks;
               d.falls = '0;
               d.nrx = '0;
               d.cnt = HALF_LAST;
               d.st = H_HIGH;
            end
         end
         H_HIGH: begin
            if (q.cnt != 8'h00) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               if (q.nrx < 4'(WORD_W)) begin
                  d.rx = {q.rx[WORD_W-2:0], q.sdo_sync[1]};
                  d.nrx = q.nrx + 1'b1;
               end
               if (q.falls < q.target) begin
                  d.sclk = 1'b0;
                  d.falls = q.falls + 1'b1;
                  d.cnt = HALF_LAST;
                  d.st = H_LOW;
               end else begin
                  d.cs_n = 1'b1;
                  d.cnt = GAP_LAST;
                  d.st = H_GAP;
                  d.first = 1'b0;
                  d.push = ~q.first && q.target >= WORD_FALLS;
                  d.push_data = q.rx[CODE_W-1:0];
               end
            end
         end
         H_LOW: begin
            if (q.cnt != 8'h00) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.sclk = 1'b1;
               d.cnt = HALF_LAST;
               d.st = H_HIGH;
            end
         end
         H_GAP: begin
            if (q.cnt != 8'h00) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.st = H_IDLE;
            end
         end
         default: begin
            d = HOST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= HOST_RESET;
      end else begin
         q <= d;
      end
   end

   result_fifo #(.W(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(q.push),
      .in_ready(push_ready),
      .in_data(q.push_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   assign link.cs_n = q.cs_n;
   assign link.sclk = q.sclk;
   assign busy = (q.st != H_IDLE) | ~push_ready;
endmodule

// *** tb/sar_frame_sva.sv ***
/* Checker on the serial link between converter and host ends.
   Assumes it sits beside the link interface, sampling on the system clock. */
`timescale 1ns/1ns
module sar_frame_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdo,
   input wire logic sdo_oe_n,
   input wire logic sdo_line
);
   logic sclk_q;
   logic sel_q;
   logic first_q;
   logic [5:0] falls_q;
   logic [3:0] since_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Fall count and age of last edge; device lags pins by its sync flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b1;
         sel_q <= 1'b0;
         first_q <= 1'b1;
         falls_q <= 6'h00;
         since_q <= 4'h0;
      end else begin
         sclk_q <= sclk;
         sel_q <= !cs_n;
         if (sel_q && cs_n) first_q <= 1'b0;
         if (cs_n) falls_q <= 6'h00;
         else if (sclk_q && !sclk && falls_q != 6'h3F) falls_q <= falls_q + 6'h01;
         if (cs_n || (sclk_q && !sclk)) since_q <= 4'h0;
         else if (since_q != 4'hF) since_q <= since_q + 4'h1;
      end
   end
   sequence s_open;
      $fell(cs_n);
   endsequence
   sequence s_close;
      $rose(cs_n);
   endsequence
   a_first_zero_drive: assert property (s_open |-> ##[2:4] (!sdo_oe_n && !sdo))
      else $error("first zero missing");
   a_frame_keeps_drive: assert property (!cs_n [*5] |-> !sdo_oe_n)
      else $error("released in frame");
   a_close_release: assert property (s_close |-> ##[2:4] sdo_oe_n)
      else $error("not released");
   a_idle_released: assert property (cs_n [*5] |-> sdo_oe_n)
      else $error("driven while idle");
   a_second_zero: assert property ((falls_q == 6'h01 && since_q > 4'h3) |-> !sdo)
      else $error("second bit not zero");
   a_bit_on_fall: assert property ($changed(sdo) |-> since_q < 4'h5)
      else $error("bit changed off a fall");
   a_tail_low: assert property ((falls_q > 6'h0C || (falls_q == 6'h0C && since_q > 4'h3))
      |-> !sdo_line)
      else $error("data high after word");
   a_cal_frame_low: assert property ((first_q && !cs_n) |-> !sdo_line)
      else $error("data high in first frame");
   a_setup_before_clock: assert property (s_open |-> sclk [*3])
      else $error("clock fell too soon");
   a_clock_idle_high: assert property (cs_n |-> sclk)
      else $error("clock low outside frame");
   a_gap_after_frame: assert property (s_close |-> cs_n [*5])
      else $error("select gap short");
   a_clock_low_hold: assert property ($fell(sclk) |-> !sclk [*3])
      else $error("clock low phase short");
endmodule

// *** tb/sar_adc_serial_frame_offset_cal_test.sv ***
/* Bench joining converter and host ends over the link, random and corner frames.
   Assumes a 50 ns clock; HALF is cut to 4 to shorten frames. */
`timescale 1ns/1ns
module sar_adc_serial_frame_offset_cal_test;
   import sar_frame_pkg::*;
   localparam int HALF = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic out_ready = 1'b0;
   logic [CNT_W-1:0] frame_clocks = 6'h00;
   logic [CODE_W-1:0] pos = 10'h000;
   logic signed [NEG_W-1:0] neg = 7'h00;
   logic signed [OFFSET_W-1:0] sense = 6'h15;
   logic disc, fact, rvalid, cdone, busy, ovalid;
   logic [CODE_W-1:0] rcode, odata;
   logic sclk_p = 1'b1;
   logic [15:0] wire_q = 16'h0000;
   logic signed [OFFSET_W-1:0] store;
   logic [CODE_W-1:0] expq[$];
   logic [16:0] corner[6] = '{{10'h000, 7'h3F}, {10'h3FF, 7'h40}, {10'h200, 7'h00},
      {10'h001, 7'h00}, {10'h3FF, 7'h00}, {10'h000, 7'h40}};
   int mismatches = 0;
   int n_checks = 0;
   int seed = 11339;
   int ncal = 0;
   int ndisc = 0;
   int nval = 0;
   int nact = 0;
   int c0, d0, r;
   bit first;
   always #25 clk = ~clk;
   adc_link_if adc_link_if_inst ();
   sar_frame_device sar_frame_device_inst (.clk(clk), .rstn(rstn),
      .link(adc_link_if_inst.device), .analog_in_pos(pos), .analog_in_neg(neg),
      .offset_sense(sense), .inputs_disconnect(disc), .frame_active(fact),
      .result_code(rcode), .result_valid(rvalid), .cal_done(cdone));
   sar_frame_host #(.HALF(HALF)) sar_frame_host_inst (.clk(clk), .rstn(rstn),
      .link(adc_link_if_inst.host), .start(start), .frame_clocks(frame_clocks),
      .busy(busy), .out_valid(ovalid), .out_ready(out_ready), .out_data(odata));
   sar_frame_sva sar_frame_sva_inst (.clk(clk), .rstn(rstn), .cs_n(adc_link_if_inst.cs_n),
      .sclk(adc_link_if_inst.sclk), .sdo(adc_link_if_inst.sdo),
      .sdo_oe_n(adc_link_if_inst.sdo_oe_n), .sdo_line(adc_link_if_inst.sdo_line));
   // Line sampled just before the device reacts to each fall
   always @(posedge clk) begin
      sclk_p <= adc_link_if_inst.sclk;
      if (sclk_p && !adc_link_if_inst.sclk) wire_q <= {wire_q[14:0], adc_link_if_inst.sdo_line};
      if (cdone === 1'b1) ncal <= ncal + 1;
      if (disc === 1'b1) ndisc <= ndisc + 1;
      if (rvalid === 1'b1) nval <= nval + 1;
      if (fact === 1'b1) nact <= nact + 1;
   end
   function automatic logic [CODE_W-1:0] want(logic [CODE_W-1:0] p,
      logic signed [NEG_W-1:0] n, logic signed [OFFSET_W-1:0] s);
      int v;
      v = int'(p) - int'(n) - int'(s);
      if (v < 0) v = 0;
      if (v > int'(TOP_SCALE_CODE)) v = int'(TOP_SCALE_CODE);
      return v[CODE_W-1:0];
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp, string m);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
         if (k > 3000) begin
            mismatches++;
            $display("ERROR %0t wait timed out", $time);
            summarize();
         end
      end while (busy !== 1'b0);
   endtask
   task automatic launch(int n, logic [CODE_W-1:0] p, logic signed [NEG_W-1:0] g);
      wait_idle();
      @(posedge clk);
      pos <= p;
      neg <= g;
      frame_clocks <= n[CNT_W-1:0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      if (!first && n >= 12) expq.push_back(want(p, g, store));
      first = 1'b0;
   endtask
   task automatic run(int n, logic [CODE_W-1:0] p, logic signed [NEG_W-1:0] g);
      int v0;
      int a0;
      v0 = nval;
      a0 = nact;
      launch(n, p, g);
      wait_idle();
      cmp(10'(nval - v0), 10'h001, "valid pulse");
      cmp(10'(nact - a0), 10'((2 * n + 1) * HALF), "frame span");
      cmp({9'h000, fact}, 10'h000, "frame closed");
      cmp(rcode, want(p, g, store), "code");
      cmp(wire_q[9:0], want(p, g, store), "wire code");
      cmp({8'h00, wire_q[11:10]}, 10'h000, "lead zeros");
   endtask
   task automatic drain();
      int k;
      k = 0;
      while (expq.size() > 0 && k < 300) begin
         @(negedge clk);
         k++;
         if (ovalid === 1'b1) begin
            cmp(odata, expq.pop_front(), "fifo word");
            @(posedge clk);
            out_ready <= 1'b1;
            @(posedge clk);
            out_ready <= 1'b0;
         end
      end
      if (expq.size() > 0) begin
         mismatches++;
         $display("ERROR %0t drain timed out", $time);
      end
      @(negedge clk);
      cmp({9'h000, ovalid}, 10'(expq.size()), "fifo empty");
   endtask
   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      first = 1'b1;
      store = 6'h00;
      expq.delete();
   endtask
   initial begin
      do_reset();
      c0 = ncal;
      launch(8, TOP_SCALE_CODE, 7'h00);
      wait_idle();
      cmp(10'(ncal - c0), 10'h000, "short cal");
      cmp({2'b00, wire_q[7:0]}, 10'h000, "cal data");
      run(12, TOP_SCALE_CODE, 7'h00);
      // Second reset mid-run, then a full power-up calibration
      do_reset();
      r = $random(seed);
      sense <= r[5:0];
      c0 = ncal;
      launch(16, 10'h000, 7'h00);
      wait_idle();
      cmp(10'(ncal - c0), 10'h001, "pwrup cal");
      cmp(wire_q[9:0], 10'h000, "cal data");
      store = sense;
      foreach (corner[i]) run(12, corner[i][16:7], corner[i][6:0]);
      repeat (6) begin
         r = $random(seed);
         run(12, r[9:0], r[16:10]);
      end
      // Empty the FIFO before it fills and stalls the host
      drain();
      // Changed sense must not reach the store on a 31-clock frame
      @(posedge clk);
      sense <= ~sense;
      c0 = ncal;
      launch(31, 10'h200, 7'h00);
      wait_idle();
      cmp(10'(ncal - c0), 10'h000, "short recal");
      run(12, 10'h200, 7'h00);
      d0 = ndisc;
      launch(32, 10'h100, 7'h00);
      wait_idle();
      cmp(10'(ncal - c0), 10'h001, "recal");
      cmp(10'(ndisc - d0), 10'(30 * HALF), "cal span");
      cmp(wire_q[9:0] | {4'h0, wire_q[15:10]}, 10'h000, "tail low");
      store = sense;
      run(12, 10'h200, 7'h00);
      // Frame cut before the word ends: no FIFO word may follow
      launch(8, 10'h155, 7'h00);
      wait_idle();
      drain();
      // Fill the FIFO with no reader; the host must then refuse
      repeat (16) begin
         r = $random(seed);
         launch(12, r[9:0], r[16:10]);
      end
      repeat (300) @(negedge clk);
      cmp({9'h000, busy}, 10'h001, "full refuses");
      drain();
      summarize();
   end
endmodule
